// ---- hdl/agu_pkg.sv ----
// Shared constants and carrier types for the address generation unit
package agu_pkg;

	localparam int ADDR_W = 16;
	localparam int SEL_W = 4;
	localparam int PIVOT_W = 15;

	// Pointer select code of the stack pointer
	localparam logic [SEL_W-1:0] STACK_SEL = 4'hF;

	// Address steps for byte and word operands
	localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
	localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
	localparam logic [ADDR_W-1:0] ZERO_ADDR = 16'h0000;

	// Output reset values
	localparam logic [ADDR_W-1:0] EA_RESET = 16'h0000;
	localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;

	typedef enum logic [2:0] {
		AGU_MODE_INDIRECT = 3'h0,
		AGU_MODE_POST_INC = 3'h1,
		AGU_MODE_POST_DEC = 3'h2,
		AGU_MODE_PRE_INC = 3'h3,
		AGU_MODE_PRE_DEC = 3'h4,
		AGU_MODE_REG_OFFSET = 3'h5
	} agu_mode_type;

	// One address request from instruction decode
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [ADDR_W-1:0] ptr;
		agu_mode_type mode;
		logic word;
		logic [ADDR_W-1:0] offset;
	} agu_req_type;

	// One computed address with its pointer write-back
	typedef struct packed {
		logic [ADDR_W-1:0] ea;
		logic wb_en;
		logic [SEL_W-1:0] wb_sel;
		logic [ADDR_W-1:0] wb_val;
		logic bitrev;
		logic circ;
	} agu_res_type;

	// Circular buffer settings
	typedef struct packed {
		logic enable;
		logic [SEL_W-1:0] sel;
		logic [ADDR_W-1:0] start_addr;
		logic [ADDR_W-1:0] end_addr;
	} agu_circ_type;

endpackage

// ---- hdl/agu_modulo_unit.sv ----
// Circular buffer boundary correction for one address generator
`timescale 1ns/1ps
`default_nettype none
module agu_modulo_unit #(
	parameter int AW = 16
) (
	input wire logic en_i,
	input wire logic [AW-1:0] base_i,
	input wire logic [AW-1:0] step_i,
	input wire logic [AW-1:0] lo_i,
	input wire logic [AW-1:0] hi_i,
	output logic [AW-1:0] addr_o,
	output logic wrapped_o
);

	initial begin
		if (AW < 2) begin
			$error("agu_modulo_unit: AW must be at least 2");
		end
	end

	logic [AW-1:0] sum;
	logic [AW-1:0] len;
	logic going_down;

	assign sum = base_i + step_i;
	assign len = hi_i - lo_i + {{(AW-1){1'b0}}, 1'b1};
	assign going_down = step_i[AW-1];

	// Compare beyond the boundary, so a large step still wraps
	always_comb begin
		addr_o = sum;
		wrapped_o = 1'b0;
		if (en_i && !going_down && (sum > hi_i)) begin
			addr_o = sum - len;
			wrapped_o = 1'b1;
		end else if (en_i && going_down && (sum < lo_i)) begin
			addr_o = sum + len;
			wrapped_o = 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- hdl/agu_addr_gen.sv ----
// Effective address generation with circular and bit-reversed modes
`timescale 1ns/1ps
`default_nettype none
module agu_addr_gen #(
	parameter int AW = 16,
	parameter int PW = 15
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_req_valid_i,
	input wire agu_pkg::agu_req_type rd_req_i,
	input wire logic wr_req_valid_i,
	input wire agu_pkg::agu_req_type wr_req_i,
	input wire agu_pkg::agu_circ_type circ_cfg_i,
	input wire logic [agu_pkg::SEL_W-1:0] bitrev_pointer_select_i,
	input wire logic bitrev_enable_bit_i,
	input wire logic [PW-1:0] bitrev_pivot_modifier_i,
	output logic rd_res_valid_o,
	output agu_pkg::agu_res_type rd_res_o,
	output logic wr_res_valid_o,
	output agu_pkg::agu_res_type wr_res_o
);

	initial begin
		if (AW != agu_pkg::ADDR_W || PW != AW - 1) begin
			$error("agu_addr_gen: widths must match the package");
		end
	end

	// Reverse bit order of an address word
	function automatic logic [AW-1:0] rev_bits(input logic [AW-1:0] v);
		logic [AW-1:0] r;
		r = '0;
		for (int i = 0; i < AW; i++) begin
			r[i] = v[AW-1-i];
		end
		return r;
	endfunction

	// Step implied by the addressing mode and operand size
	function automatic logic [AW-1:0] mode_step(
		input agu_pkg::agu_req_type q
	);
		logic [AW-1:0] s;
		s = q.word ? agu_pkg::WORD_STEP : agu_pkg::BYTE_STEP;
		unique case (q.mode)
			agu_pkg::AGU_MODE_POST_INC,
			agu_pkg::AGU_MODE_PRE_INC: begin
				mode_step = s;
			end
			agu_pkg::AGU_MODE_POST_DEC,
			agu_pkg::AGU_MODE_PRE_DEC: begin
				mode_step = agu_pkg::ZERO_ADDR - s;
			end
			agu_pkg::AGU_MODE_REG_OFFSET: begin
				mode_step = q.offset;
			end
			default: begin
				mode_step = agu_pkg::ZERO_ADDR;
			end
		endcase
	endfunction

	function automatic logic is_pre(input agu_pkg::agu_mode_type m);
		return m == agu_pkg::AGU_MODE_PRE_INC ||
			m == agu_pkg::AGU_MODE_PRE_DEC;
	endfunction

	function automatic logic is_post(input agu_pkg::agu_mode_type m);
		return m == agu_pkg::AGU_MODE_POST_INC ||
			m == agu_pkg::AGU_MODE_POST_DEC;
	endfunction

	// Circular correction qualifies on the configured pointer only
	logic rd_circ_hit;
	logic wr_circ_hit;
	logic wr_bitrev_act;
	logic wr_circ_en;

	assign rd_circ_hit = circ_cfg_i.enable &&
		(rd_req_i.sel == circ_cfg_i.sel);
	assign wr_circ_hit = circ_cfg_i.enable &&
		(wr_req_i.sel == circ_cfg_i.sel);

	// Every qualifier must hold, otherwise ordinary or circular addressing applies
	assign wr_bitrev_act = bitrev_enable_bit_i &&
		(bitrev_pointer_select_i != agu_pkg::STACK_SEL) &&
		(wr_req_i.sel == bitrev_pointer_select_i) &&
		wr_req_i.word &&
		(wr_req_i.mode == agu_pkg::AGU_MODE_PRE_INC ||
		wr_req_i.mode == agu_pkg::AGU_MODE_POST_INC);

	// Bit reversal takes the write generator away from circular mode
	assign wr_circ_en = wr_circ_hit && !wr_bitrev_act;

	logic [AW-1:0] rd_mod_addr;
	logic rd_wrapped;
	logic [AW-1:0] wr_mod_addr;
	logic wr_wrapped;

	agu_modulo_unit #(
		.AW(AW)
	) u_rd_modulo (
		.en_i(rd_circ_hit),
		.base_i(rd_req_i.ptr),
		.step_i(mode_step(rd_req_i)),
		.lo_i(circ_cfg_i.start_addr),
		.hi_i(circ_cfg_i.end_addr),
		.addr_o(rd_mod_addr),
		.wrapped_o(rd_wrapped)
	);

	agu_modulo_unit #(
		.AW(AW)
	) u_wr_modulo (
		.en_i(wr_circ_en),
		.base_i(wr_req_i.ptr),
		.step_i(mode_step(wr_req_i)),
		.lo_i(circ_cfg_i.start_addr),
		.hi_i(circ_cfg_i.end_addr),
		.addr_o(wr_mod_addr),
		.wrapped_o(wr_wrapped)
	);

	// Reverse-carry add: pointer and pivot are both reversed, summed, then reversed back
	logic [AW-1:0] pivot_bytes;
	logic [AW-1:0] bitrev_next;

	assign pivot_bytes = {bitrev_pivot_modifier_i, 1'b0};
	always_comb begin
		bitrev_next = rev_bits(rev_bits(wr_req_i.ptr) +
			rev_bits(pivot_bytes));
		bitrev_next[0] = 1'b0;
	end

	// Read generator never reverses bits, only corrects circularly
	agu_pkg::agu_res_type rd_res_d;
	always_comb begin
		rd_res_d = '0;
		rd_res_d.wb_sel = rd_req_i.sel;
		rd_res_d.circ = rd_circ_hit && rd_wrapped;
		if (is_pre(rd_req_i.mode) ||
			rd_req_i.mode == agu_pkg::AGU_MODE_REG_OFFSET) begin
			rd_res_d.ea = rd_mod_addr;
		end else begin
			rd_res_d.ea = rd_req_i.ptr;
		end
		if (is_pre(rd_req_i.mode) || is_post(rd_req_i.mode)) begin
			rd_res_d.wb_en = 1'b1;
			rd_res_d.wb_val = rd_mod_addr;
		end else begin
			rd_res_d.wb_en = 1'b0;
			rd_res_d.wb_val = rd_req_i.ptr;
		end
	end

	// Write generator: bit-reversed path or ordinary/circular path
	agu_pkg::agu_res_type wr_res_d;
	always_comb begin
		wr_res_d = '0;
		wr_res_d.wb_sel = wr_req_i.sel;
		wr_res_d.bitrev = wr_bitrev_act;
		wr_res_d.circ = wr_circ_en && wr_wrapped;
		if (wr_bitrev_act) begin
			wr_res_d.wb_en = 1'b1;
			wr_res_d.wb_val = bitrev_next;
			if (wr_req_i.mode == agu_pkg::AGU_MODE_PRE_INC) begin
				wr_res_d.ea = bitrev_next;
			end else begin
				wr_res_d.ea = {wr_req_i.ptr[AW-1:1], 1'b0};
			end
		end else begin
			if (is_pre(wr_req_i.mode) ||
				wr_req_i.mode == agu_pkg::AGU_MODE_REG_OFFSET) begin
				wr_res_d.ea = wr_mod_addr;
			end else begin
				wr_res_d.ea = wr_req_i.ptr;
			end
			if (is_pre(wr_req_i.mode) || is_post(wr_req_i.mode)) begin
				wr_res_d.wb_en = 1'b1;
				wr_res_d.wb_val = wr_mod_addr;
			end else begin
				wr_res_d.wb_en = 1'b0;
				wr_res_d.wb_val = wr_req_i.ptr;
			end
		end
	end

	// Results are registered so the address bus sees clean data
	logic rd_valid_q;
	logic wr_valid_q;
	agu_pkg::agu_res_type rd_res_q;
	agu_pkg::agu_res_type wr_res_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req_valid_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_valid_q <= 1'b0;
		end else begin
			wr_valid_q <= wr_req_valid_i;
		end
	end

	// Results hold their last value between requests
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_res_q <= '0;
		end else if (rd_req_valid_i) begin
			rd_res_q <= rd_res_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_res_q <= '0;
		end else if (wr_req_valid_i) begin
			wr_res_q <= wr_res_d;
		end
	end

	// Write-back strobe is gated so a held result never updates twice
	always_comb begin
		rd_res_o = rd_res_q;
		rd_res_o.wb_en = rd_res_q.wb_en && rd_valid_q;
		wr_res_o = wr_res_q;
		wr_res_o.wb_en = wr_res_q.wb_en && wr_valid_q;
	end

	assign rd_res_valid_o = rd_valid_q;
	assign wr_res_valid_o = wr_valid_q;

endmodule
`default_nettype wire

// ---- verification/agu_addr_gen_asserts.sv ----
// Port assertions for the address generator
`timescale 1ns/1ps
`default_nettype none
module agu_addr_gen_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_req_valid_i,
	input wire agu_pkg::agu_req_type rd_req_i,
	input wire logic wr_req_valid_i,
	input wire agu_pkg::agu_req_type wr_req_i,
	input wire agu_pkg::agu_circ_type circ_cfg_i,
	input wire logic [agu_pkg::SEL_W-1:0] bitrev_pointer_select_i,
	input wire logic bitrev_enable_bit_i,
	input wire logic rd_res_valid_o,
	input wire agu_pkg::agu_res_type rd_res_o,
	input wire logic wr_res_valid_o,
	input wire agu_pkg::agu_res_type wr_res_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_rd_pre;
		rd_req_valid_i && rd_req_i.mode == agu_pkg::AGU_MODE_PRE_INC;
	endsequence
	property p_rd_lat;
		rd_req_valid_i |=> rd_res_valid_o;
	endproperty
	property p_wr_lat;
		!wr_req_valid_i |=> !wr_res_valid_o;
	endproperty
	property p_rd_nobr;
		rd_res_valid_o |-> !rd_res_o.bitrev;
	endproperty
	property p_br_off;
		wr_req_valid_i && (!bitrev_enable_bit_i || !wr_req_i.word ||
			bitrev_pointer_select_i == agu_pkg::STACK_SEL) |=> !wr_res_o.bitrev;
	endproperty
	property p_br_lsb;
		wr_res_valid_o && wr_res_o.bitrev |-> !wr_res_o.ea[0] &&
			!wr_res_o.wb_val[0] && !wr_res_o.circ;
	endproperty
	property p_ofs;
		rd_req_valid_i && rd_req_i.mode == agu_pkg::AGU_MODE_REG_OFFSET
			|=> !rd_res_o.wb_en;
	endproperty
	property p_pre;
		s_rd_pre |=> rd_res_o.wb_en && rd_res_o.ea == rd_res_o.wb_val &&
			rd_res_o.wb_sel == $past(rd_req_i.sel);
	endproperty
	property p_wrap;
		s_rd_pre ##1 rd_res_o.circ |-> rd_res_o.ea >= circ_cfg_i.start_addr
			&& rd_res_o.ea <= circ_cfg_i.end_addr;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read late");
	a_wr_lat: assert property (p_wr_lat) else $error("stray write");
	a_rd_nobr: assert property (p_rd_nobr) else $error("read bitrev");
	a_br_off: assert property (p_br_off) else $error("bitrev on");
	a_br_lsb: assert property (p_br_lsb) else $error("bitrev lsb");
	a_ofs: assert property (p_ofs) else $error("offset write-back");
	a_pre: assert property (p_pre) else $error("pre write-back");
	a_wrap: assert property (p_wrap) else $error("wrap bound");
endmodule
bind agu_addr_gen agu_addr_gen_chk u_chk (.*);
`default_nettype wire

// ---- verification/agu_dec_model.sv ----
// Decode-side model that issues requests to the generator
`timescale 1ns/1ps
`default_nettype none
module agu_dec_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_valid_i,
	input wire logic wr_valid_i,
	input wire logic [3:0] rd_sel_i,
	input wire logic [3:0] br_sel_i,
	input wire logic br_en_i,
	output logic rd_valid_o,
	output logic wr_valid_o
);
	logic [4:0] cfg_q;
	always_ff @(posedge clk_i) begin
		cfg_q <= {br_en_i, br_sel_i};
	end
	// A read through the bit-reverse pointer is dropped in the cycle that a control update with bit reversal enabled arrives
	assign rd_valid_o = rd_valid_i && !rst_i && !(br_en_i &&
		cfg_q != {br_en_i, br_sel_i} && rd_sel_i == br_sel_i);
	assign wr_valid_o = wr_valid_i && !rst_i;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
$display("wrong value at %0t: %h %h", $time, g, e); end end
module testbench;
	logic clk_i = 0, rst_i = 1, rv = 0, wv = 0, be = 0, rvq, wvq, rdv, wrv;
	logic [3:0] bs = 4'hF;
	logic [14:0] pv = 15'h0004;
	logic [31:0] rs = 32'h39E6;
	int miscompares, n_checks;
	agu_pkg::agu_req_type rq = '0, wq = '0;
	agu_pkg::agu_circ_type cc = '0;
	agu_pkg::agu_res_type ro, wo, qr[$], qw[$];
	agu_dec_model u_dec (.clk_i, .rst_i, .rd_valid_i(rv), .wr_valid_i(wv),
		.rd_sel_i(rq.sel), .br_sel_i(bs), .br_en_i(be), .rd_valid_o(rvq),
		.wr_valid_o(wvq));
	agu_addr_gen u_dut (.clk_i, .rst_i, .rd_req_valid_i(rvq), .rd_req_i(rq),
		.wr_req_valid_i(wvq), .wr_req_i(wq), .circ_cfg_i(cc),
		.bitrev_pointer_select_i(bs), .bitrev_enable_bit_i(be),
		.bitrev_pivot_modifier_i(pv), .rd_res_valid_o(rdv), .rd_res_o(ro),
		.wr_res_valid_o(wrv), .wr_res_o(wo));
	initial forever #2 clk_i = ~clk_i;
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic agu_pkg::agu_req_type mk(logic [31:0] r);
		agu_pkg::agu_req_type q;
		q.sel = {2'b00, r[1:0]};
		q.ptr = {11'h080, r[6:2]};
		q.mode = agu_pkg::agu_mode_type'(3'(r[9:7] % 6));
		q.word = r[10];
		q.offset = {{10{r[16]}}, r[16:11]};
		return q;
	endfunction
	function automatic agu_pkg::agu_res_type ref_res(agu_pkg::agu_req_type q,
		bit w);
		agu_pkg::agu_res_type r;
		logic [15:0] s, x, y;
		int m;
		bit dn;
		m = q.mode;
		r = '0;
		dn = m == 2 || m == 4 || (m == 5 && q.offset[15]);
		s = q.word ? 16'h0002 : 16'h0001;
		s = m == 5 ? q.offset : m == 0 ? 16'h0000 : dn ? -s : s;
		s = q.ptr + s;
		r.wb_en = m > 0 && m < 5;
		r.wb_sel = q.sel;
		r.ea = q.ptr;
		if (w && be && bs != 4'hF && q.sel == bs && q.word &&
			(m == 1 || m == 3)) begin
			x = {<<{q.ptr & 16'hFFFE}};
			y = {<<{pv, 1'b0}};
			x = x + y;
			s = {<<{x}};
			s[0] = 1'b0;
			r.ea = q.ptr & 16'hFFFE;
			r.bitrev = 1;
		end else if (cc.enable && q.sel == cc.sel && m > 0) begin
			x = cc.end_addr - cc.start_addr + 16'h0001;
			r.circ = dn ? s < cc.start_addr : s > cc.end_addr;
			if (r.circ) s = dn ? s + x : s - x;
		end
		if (m > 2) r.ea = s;
		r.wb_val = s;
		return r;
	endfunction
	task automatic cmp(agu_pkg::agu_res_type g, e);
		`CHK(g.ea, e.ea)
		`CHK(g.wb_en, e.wb_en)
		if (e.wb_en) `CHK({g.wb_sel, g.wb_val}, {e.wb_sel, e.wb_val})
		`CHK(g.bitrev, e.bitrev)
		`CHK(g.circ, e.circ)
	endtask
	always @(posedge clk_i) begin
		if (rst_i) begin
			qr = {};
			qw = {};
		end
		if (rvq) qr.push_back(ref_res(rq, 0));
		if (wvq) qw.push_back(ref_res(wq, 1));
	end
	// Exactly one expected result waits whenever a valid shows
	always @(negedge clk_i) begin
		`CHK(rdv, qr.size() == 1)
		`CHK(wrv, qw.size() == 1)
		if (rdv) cmp(ro, qr.pop_front());
		if (wrv) cmp(wo, qw.pop_front());
	end
	task automatic rst_seq(int n);
		@(posedge clk_i);
		rv <= 0;
		wv <= 0;
		rst_i <= 1;
		repeat (n - 1) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic run(int n);
		logic [31:0] r;
		repeat (n) begin
			@(posedge clk_i);
			r = xs();
			rv <= r[0];
			wv <= r[1];
			rq <= mk(r >> 2);
			wq <= mk(r >> 7);
			cc.enable <= r[31];
			if (r[30:29] == 0) begin
				be <= r[28];
				bs <= r[27:26] == 0 ? 4'hF : {2'b00, r[27:26]};
				pv <= 15'h0001 << r[25:24];
			end
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		test_done();
	end
	initial begin
		cc <= '{1'b1, 4'h1, 16'h1000, 16'h101F};
		rst_seq(12);
		run(2000);
		rst_seq(3);
		run(2000);
		@(posedge clk_i);
		rv <= 0;
		wv <= 0;
		repeat (3) @(posedge clk_i);
		test_done();
	end
endmodule
`default_nettype wire
